/* File: verilog/crxbs_steer.sv */
// receive buffer steering: filter hit to buffer or FIFO, full and overflow flags
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "crxbs_defs.svh"

module crxbs_steer
	import crxbs_pkg::*;
(
	// clock and reset
	input	wire logic		clk,
	input	wire logic		rstn,
	// register port
	input	wire logic [3:0]	reg_addr,
	input	wire logic [15:0]	reg_wdata,
	input	wire logic		reg_wr,
	input	wire logic		reg_rd,
	output	logic [15:0]		reg_rdata,
	// acceptance filter hits
	input	wire logic		hit_valid,
	input	wire logic [3:0]	hit_filter,
	input	wire logic [15:0]	filt0_3_pointer,
	// store request to the message mover
	output	logic			store_valid,
	output	logic [4:0]		store_slot,
	output	logic			store_fifo,
	// interrupt
	output	logic			irq
);

	crxbs_state_type	s_r;
	crxbs_state_type	s_nxt;

	crxbs_ptr_if	wr_if ();
	crxbs_ptr_if	rd_if ();

	crxbs_fifo_ptr u_wr_ptr (
		.clk	(clk),
		.rstn	(rstn),
		.pif	(wr_if.cnt)
	);

	crxbs_fifo_ptr u_rd_ptr (
		.clk	(clk),
		.rstn	(rstn),
		.pif	(rd_if.cnt)
	);

	logic [63:0]	all_ptrs;
	logic [3:0]	hit_code;
	logic [4:0]	target;
	logic [4:0]	last_slot;
	logic		to_fifo;
	logic [31:0]	set_full;
	logic [31:0]	set_ovf;
	logic [2:0]	irq_set;
	logic		wr_fctrl;

	// slot count code to index of the last buffer; reserved code kept at full size
	always_comb begin
		case (s_r.size)
			3'h0: last_slot = `CRXBS_LAST_4;
			3'h1: last_slot = `CRXBS_LAST_6;
			3'h2: last_slot = `CRXBS_LAST_8;
			3'h3: last_slot = `CRXBS_LAST_12;
			3'h4: last_slot = `CRXBS_LAST_16;
			3'h5: last_slot = `CRXBS_LAST_24;
			default: last_slot = `CRXBS_LAST_32;
		endcase
	end

	// filter n owns bits 4n+3..4n; highest filter of a register in 15-12
	assign all_ptrs = {s_r.ptr12_15, s_r.ptr8_11, s_r.ptr4_7, filt0_3_pointer};
	assign hit_code = all_ptrs[{hit_filter, 2'b00} +: 4];
	assign to_fifo  = (hit_code == `CRXBS_FIFO_CODE);
	assign target   = to_fifo ? wr_if.ptr : {1'b0, hit_code};

	always_comb begin
		set_full = '0;
		set_ovf  = '0;
		irq_set  = '0;
		if (hit_valid) begin
			if (s_r.full[target]) begin
				set_ovf[target]          = 1'b1;
				irq_set[`CRXBS_IRQ_OVR]  = 1'b1;
			end else begin
				set_full[target]         = 1'b1;
				irq_set[`CRXBS_IRQ_RX]   = 1'b1;
				irq_set[`CRXBS_IRQ_FIFO] = to_fifo;
			end
		end
	end

	assign wr_fctrl = reg_wr && (reg_addr == `CRXBS_A_FCTRL);

	always_comb begin
		s_nxt = s_r;
		s_nxt.store_valid = 1'b0;
		s_nxt.rd_data     = `CRXBS_RESET16;
		if (reg_wr) begin
			case (reg_addr)
				`CRXBS_A_PTR4_7: begin
					s_nxt.ptr4_7 = reg_wdata;
				end
				`CRXBS_A_PTR8_11: begin
					s_nxt.ptr8_11 = reg_wdata;
				end
				`CRXBS_A_PTR12_15: begin
					s_nxt.ptr12_15 = reg_wdata;
				end
				`CRXBS_A_FULL_LO: begin
					s_nxt.full[15:0] = s_r.full[15:0] & reg_wdata;
				end
				`CRXBS_A_FULL_HI: begin
					s_nxt.full[31:16] = s_r.full[31:16] & reg_wdata;
				end
				`CRXBS_A_OVF_LO: begin
					s_nxt.ovf[15:0] = s_r.ovf[15:0] & reg_wdata;
				end
				`CRXBS_A_OVF_HI: begin
					s_nxt.ovf[31:16] = s_r.ovf[31:16] & reg_wdata;
				end
				`CRXBS_A_FCTRL: begin
					s_nxt.size = reg_wdata[`CRXBS_SIZE_MSB:`CRXBS_SIZE_LSB];
					s_nxt.fifo_first_slot  = reg_wdata[`CRXBS_FSA_MSB:`CRXBS_FSA_LSB];
				end
				`CRXBS_A_IRQ_CLR: begin
					s_nxt.irq_st = s_r.irq_st & ~reg_wdata[`CRXBS_IRQ_W-1:0];
				end
				`CRXBS_A_IRQ_EN: begin
					s_nxt.irq_en = reg_wdata[`CRXBS_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a clear in the same cycle
		s_nxt.full   = s_nxt.full | set_full;
		s_nxt.ovf    = s_nxt.ovf | set_ovf;
		s_nxt.irq_st = s_nxt.irq_st | irq_set;
		s_nxt.irq    = |(s_nxt.irq_st & s_nxt.irq_en);
		s_nxt.store_valid = |set_full;
		if (|set_full) begin
			s_nxt.store_slot = target;
			s_nxt.store_fifo = to_fifo;
		end
		if (reg_rd) begin
			case (reg_addr)
				`CRXBS_A_PTR4_7: begin
					s_nxt.rd_data = s_r.ptr4_7;
				end
				`CRXBS_A_PTR8_11: begin
					s_nxt.rd_data = s_r.ptr8_11;
				end
				`CRXBS_A_PTR12_15: begin
					s_nxt.rd_data = s_r.ptr12_15;
				end
				`CRXBS_A_FULL_LO: begin
					s_nxt.rd_data = s_r.full[15:0];
				end
				`CRXBS_A_FULL_HI: begin
					s_nxt.rd_data = s_r.full[31:16];
				end
				`CRXBS_A_OVF_LO: begin
					s_nxt.rd_data = s_r.ovf[15:0];
				end
				`CRXBS_A_OVF_HI: begin
					s_nxt.rd_data = s_r.ovf[31:16];
				end
				`CRXBS_A_FCTRL: begin
					s_nxt.rd_data = {s_r.size, 8'h00, s_r.fifo_first_slot};
				end
				`CRXBS_A_FSTAT: begin
					s_nxt.rd_data = {3'h0, wr_if.ptr, 3'h0, rd_if.ptr};
				end
				`CRXBS_A_IRQ_ST: begin
					s_nxt.rd_data = {13'h0000, s_r.irq_st};
				end
				`CRXBS_A_IRQ_EN: begin
					s_nxt.rd_data = {13'h0000, s_r.irq_en};
				end
				default: begin
					s_nxt.rd_data = `CRXBS_RESET16;
				end
			endcase
		end
	end

	// writing the FIFO control re-aims both pointers at the new start
	assign wr_if.first   = s_nxt.fifo_first_slot;
	assign wr_if.last    = last_slot;
	assign wr_if.restart = wr_fctrl;
	assign wr_if.advance = hit_valid && to_fifo && !s_r.full[target];
	assign rd_if.first   = s_nxt.fifo_first_slot;
	assign rd_if.last    = last_slot;
	assign rd_if.restart = wr_fctrl;
	// software frees the FIFO head by clearing its full flag
	assign rd_if.advance = s_r.full[rd_if.ptr] && !s_nxt.full[rd_if.ptr];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata   = s_r.rd_data;
	assign store_valid = s_r.store_valid;
	assign store_slot  = s_r.store_slot;
	assign store_fifo  = s_r.store_fifo;
	assign irq         = s_r.irq;

endmodule

/* File: verilog/crxbs_defs.svh */
// offsets, field positions, reset values and codes of the receive buffer steering block
//
// Contract
// - a filter whose four-bit pointer holds 1111 sends its accepted messages into the receive FIFO.
// - a pointer code 0000 to 1110 sends the filter's messages into the dedicated buffer of that index.
// - each 16-bit pointer register holds four 4-bit fields, highest filter in 15-12, lowest in 3-0.
// - each of the 32 buffers has a full flag, set when a message is stored there, clear meaning empty.
// - full and overflow flags are cleared only by writing zero, and writing one leaves them alone.
// - storing into a buffer whose full flag is set instead sets that buffer's overflow flag.
// - bits 15-13 of the FIFO control select 4, 6, 8, 12, 16, 24 or 32 buffers, code 111 reserved.
// - bits 4-0 of the FIFO control select the first buffer of the FIFO area, buffer 0 to buffer 31.
// - all pointer, flag and FIFO control fields reset to zero and unimplemented bits read as zero.
// - any receive buffer overflow raises the receive overrun interrupt flag.
// - a six-bit read-only pointer names the next FIFO buffer that software should read; the code's read pointer is five bits, bits 4-0 of the FIFO status.
`ifndef CRXBS_DEFS_SVH
`define CRXBS_DEFS_SVH

`define CRXBS_A_PTR4_7    4'h0
`define CRXBS_A_PTR8_11   4'h1
`define CRXBS_A_PTR12_15  4'h2
`define CRXBS_A_FULL_LO   4'h3
`define CRXBS_A_FULL_HI   4'h4
`define CRXBS_A_OVF_LO    4'h5
`define CRXBS_A_OVF_HI    4'h6
`define CRXBS_A_FCTRL     4'h7
`define CRXBS_A_FSTAT     4'h8
`define CRXBS_A_IRQ_ST    4'h9
`define CRXBS_A_IRQ_CLR   4'ha
`define CRXBS_A_IRQ_EN    4'hb

`define CRXBS_FIFO_CODE   4'hf
`define CRXBS_SIZE_MSB    15
`define CRXBS_SIZE_LSB    13
`define CRXBS_FSA_MSB     4
`define CRXBS_FSA_LSB     0
`define CRXBS_FBP_LSB     8
`define CRXBS_IRQ_RX      0
`define CRXBS_IRQ_FIFO    1
`define CRXBS_IRQ_OVR     2
`define CRXBS_IRQ_W       3
`define CRXBS_RESET16     16'h0000

`define CRXBS_LAST_4      5'h03
`define CRXBS_LAST_6      5'h05
`define CRXBS_LAST_8      5'h07
`define CRXBS_LAST_12     5'h0b
`define CRXBS_LAST_16     5'h0f
`define CRXBS_LAST_24     5'h17
`define CRXBS_LAST_32     5'h1f

`endif

/* File: verilog/crxbs_pkg.sv */
// types of the receive buffer steering block
package crxbs_pkg;

	typedef struct packed {
		logic [15:0]	ptr4_7;
		logic [15:0]	ptr8_11;
		logic [15:0]	ptr12_15;
		logic [31:0]	full;
		logic [31:0]	ovf;
		logic [2:0]	size;
		logic [4:0]	fifo_first_slot;
		logic [2:0]	irq_st;
		logic [2:0]	irq_en;
		logic [15:0]	rd_data;
		logic		irq;
		logic		store_valid;
		logic [4:0]	store_slot;
		logic		store_fifo;
	} crxbs_state_type;

	typedef struct packed {
		logic [4:0]	ptr;
	} crxbs_ptr_state_type;

endpackage

/* File: verilog/crxbs_ptr_if.sv */
// wrapping FIFO pointer control between the steering logic and a pointer counter
interface crxbs_ptr_if;
	logic [4:0]	first;
	logic [4:0]	last;
	logic		restart;
	logic		advance;
	logic [4:0]	ptr;

	modport ctl (output first, output last, output restart, output advance, input ptr);
	modport cnt (input first, input last, input restart, input advance, output ptr);
endinterface

/* File: verilog/crxbs_fifo_ptr.sv */
// wrapping pointer over the FIFO area of message RAM
module crxbs_fifo_ptr
	import crxbs_pkg::*;
(
	// clock and reset
	input	wire logic	clk,
	input	wire logic	rstn,
	// pointer control
	crxbs_ptr_if.cnt	pif
);

	crxbs_ptr_state_type	s_r;
	crxbs_ptr_state_type	s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (pif.restart) begin
			s_nxt.ptr = pif.first;
		end else if (pif.advance) begin
			// a start beyond the last slot degenerates to a one-slot FIFO
			if (s_r.ptr >= pif.last || s_r.ptr < pif.first) begin
				s_nxt.ptr = pif.first;
			end else begin
				s_nxt.ptr = s_r.ptr + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pif.ptr = s_r.ptr;

endmodule

/* File: test/crxbs_steer_properties.sv */
// port assertions of the receive buffer steering block
module crxbs_steer_properties (
	// clock and reset
	input	wire logic		clk,
	input	wire logic		rstn,
	// register port
	input	wire logic [3:0]	reg_addr,
	input	wire logic [15:0]	reg_wdata,
	input	wire logic		reg_wr,
	input	wire logic		reg_rd,
	input	wire logic [15:0]	reg_rdata,
	// hits, stores, interrupt
	input	wire logic		hit_valid,
	input	wire logic [3:0]	hit_filter,
	input	wire logic [15:0]	filt0_3_pointer,
	input	wire logic		store_valid,
	input	wire logic [4:0]	store_slot,
	input	wire logic		store_fifo,
	input	wire logic		irq
);
	logic [3:0]	fld;

	// only filters 0-3 have their pointer field visible at the ports
	assign fld = filt0_3_pointer[{hit_filter[1:0], 2'b00} +: 4];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (reg_rd && (reg_addr == 4'ha || reg_addr > 4'hb) |=>
		reg_rdata == 16'h0) else $error("unmapped read not zero");
	a_fctrl_gap: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata[12:5] == 8'h0)
		else $error("unused control bits read set");
	a_fstat_range: assert property (reg_rd && reg_addr == 4'h8 |=>
		reg_rdata[15:13] == 3'h0 && reg_rdata[7:5] == 3'h0) else $error("pointer out of range");
	a_store_cause: assert property (store_valid |-> $past(hit_valid))
		else $error("store without a hit");
	a_slot_direct: assert property (hit_valid && !hit_filter[3:2] && fld != 4'hf |=>
		!store_valid || (!store_fifo && store_slot == {1'b0, $past(fld)}))
		else $error("dedicated buffer mismatch");
	a_slot_fifo: assert property (hit_valid && !hit_filter[3:2] && fld == 4'hf |=>
		!store_valid || store_fifo) else $error("fifo code not sent to fifo");
	a_slot_held: assert property (!store_valid |-> $stable(store_slot) && $stable(store_fifo))
		else $error("store target moved between stores");
	a_irq_masked: assert property (reg_wr && reg_addr == 4'hb && reg_wdata[2:0] == 3'h0 |->
		##[1:2] !irq) else $error("irq high while masked");
	cover property (store_valid && store_fifo);
	cover property (store_valid && !store_fifo);
	cover property (irq);
endmodule

/* File: test/crxbs_dma_model.sv */
// message mover on the store side: counts messages and marks the slots it filled
module crxbs_dma_model (
	// clock and reset
	input	wire logic		clk,
	input	wire logic		rstn,
	// store requests from the steering block
	input	wire logic		store_valid,
	input	wire logic [4:0]	store_slot,
	// tallies for the bench
	output	int			moved,
	output	logic [31:0]		landed
);
	// moving is instant, so a tally and a slot mask are all the bench needs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			moved  <= 0;
			landed <= '0;
		end else if (store_valid) begin
			moved  <= moved + 1;
			landed <= landed | (32'h1 << store_slot);
		end
	end
endmodule

/* File: test/tb.sv */
// self-checking bench of the receive buffer steering block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, hit_valid = 0;
	logic [3:0]	reg_addr = 0, hit_filter = 0;
	logic [15:0]	reg_wdata = 0, filt0_3_pointer = 0, reg_rdata;
	logic		store_valid, store_fifo, irq;
	logic [4:0]	store_slot;
	logic [31:0]	landed;
	int		moved, miscompares = 0, checked = 0;

	crxbs_steer dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.hit_valid, .hit_filter, .filt0_3_pointer, .store_valid, .store_slot, .store_fifo, .irq);
	crxbs_dma_model dma_u (.clk, .rstn, .store_valid, .store_slot, .moved, .landed);

	initial begin
		forever #4 clk = ~clk;
	end
	task automatic cmp(input string what, input logic [15:0] exp, got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 cmp($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	task automatic hit(input logic [3:0] f, input logic ev, input logic [4:0] slot, input logic fifo);
		@(posedge clk);
		hit_valid <= 1'b1;
		hit_filter <= f;
		@(posedge clk);
		hit_valid <= 1'b0;
		#1 cmp("store_valid", 16'(ev), 16'(store_valid));
		if (ev) cmp("store target", {10'h0, fifo, slot}, {10'h0, store_fifo, store_slot});
	endtask
	task automatic test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 12; a++) rd(4'(a), 16'h0);
		$display("test reset done");
		wr(4'h0, 16'hf065);
		rd(4'h0, 16'hf065);
		hit(4'h4, 1'b1, 5'd5, 1'b0);
		hit(4'h5, 1'b1, 5'd6, 1'b0);
		rd(4'h3, 16'h0060);
		wr(4'hb, 16'h0004);
		hit(4'h4, 1'b0, 5'd0, 1'b0);
		rd(4'h5, 16'h0020);
		rd(4'h9, 16'h0005);
		cmp("irq", 16'h1, 16'(irq));
		wr(4'ha, 16'h0004);
		rd(4'h9, 16'h0001);
		cmp("irq", 16'h0, 16'(irq));
		wr(4'h3, 16'hffff);
		rd(4'h3, 16'h0060);
		wr(4'h3, 16'hffdf);
		rd(4'h3, 16'h0040);
		$display("test dedicated done");
		wr(4'h7, 16'h1fe2);
		rd(4'h7, 16'h0002);
		hit(4'h7, 1'b1, 5'd2, 1'b1);
		hit(4'h7, 1'b1, 5'd3, 1'b1);
		hit(4'h7, 1'b0, 5'd0, 1'b0);
		rd(4'h5, 16'h0024);
		rd(4'h9, 16'h0007);
		rd(4'h8, 16'h0202);
		wr(4'h3, 16'hfffb);
		rd(4'h8, 16'h0203);
		hit(4'h7, 1'b1, 5'd2, 1'b1);
		$display("test fifo done");
		@(posedge clk);
		filt0_3_pointer <= 16'hf0e0;
		hit(4'h1, 1'b1, 5'd14, 1'b0);
		wr(4'h7, 16'h2004);
		rd(4'h7, 16'h2004);
		hit(4'h3, 1'b1, 5'd4, 1'b1);
		hit(4'h3, 1'b1, 5'd5, 1'b1);
		hit(4'h3, 1'b0, 5'd0, 1'b0);
		rd(4'h8, 16'h0404);
		rd(4'h5, 16'h0034);
		wr(4'h7, 16'hc01f);
		hit(4'h3, 1'b1, 5'd31, 1'b1);
		rd(4'h4, 16'h8000);
		wr(4'hb, 16'h0000);
		cmp("moved", 16'd9, 16'(moved));
		cmp("landed low", 16'h407c, landed[15:0]);
		cmp("landed high", 16'h8000, landed[31:16]);
		$display("test steering done");
		test_done;
	end
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		test_done;
	end
endmodule

bind crxbs_steer crxbs_steer_properties chk_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .hit_valid, .hit_filter, .filt0_3_pointer, .store_valid, .store_slot,
	.store_fifo, .irq);
